/* rtl/annunciator_consts.svh */
`ifndef ANNUNCIATOR_CONSTS_SVH
`define ANNUNCIATOR_CONSTS_SVH

// System clock rate and the slow timebase derived from it
`define CLK_MHZ          200
`define TICK_US          1000
`define TICK_CYCLES      (`TICK_US * `CLK_MHZ)

// Power-on settling hold after self-test
`define POWERON_S        30
`define POWERON_TICKS    (`POWERON_S * 1000000 / `TICK_US)

// Activation delay for warning / first-level conditions
`define WARN_DELAY_MIN   5
`define WARN_DELAY_TICKS (`WARN_DELAY_MIN * 60 * 1000000 / `TICK_US)

// Fault detection levels, in mV across the 250 ohm termination
`define FAULT_LO_MV      12'h064
`define FAULT_HI_MV      12'h15e

// Buzzer pattern timing, in timebase ticks (1 ms each)
`define LONG_ON_MS       16'h01f4
`define SLOW_GAP_MS      16'h01f4
`define SHORT_ON_MS      16'h0064
`define FAST_GAP_MS      16'h0064
`define PAUSE_MS         16'h03e8
`define FAULT_GAP_MS     16'h0384

// Beeps per burst
`define WARN_BEEPS       3'h2
`define ALARM_BEEPS      3'h4
`define FAULT_BEEPS      3'h1

// Counter widths
`define TICK_CNT_W       18
`define PON_CNT_W        16
`define DLY_CNT_W        19

`endif

/* rtl/annunciator_pkg.sv */
package annunciator_pkg;

  // Buzzer pattern in play
  typedef enum logic [3:0] {
    PAT_NONE  = 4'h1,
    PAT_WARN  = 4'h2,
    PAT_ALARM = 4'h4,
    PAT_FAULT = 4'h8
  } pat_t;

  // Beep sequencer phase
  typedef enum logic [3:0] {
    BS_IDLE  = 4'h1,
    BS_ON    = 4'h2,
    BS_GAP   = 4'h4,
    BS_PAUSE = 4'h8
  } beep_state_t;

endpackage : annunciator_pkg

/* rtl/hold_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "annunciator_consts.svh"

// Qualifies one threshold condition with an optional activation delay
module hold_timer #(
  parameter int W     = `DLY_CNT_W,
  parameter int LIMIT = `WARN_DELAY_TICKS
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tick,    // Timebase pulse
  input  wire logic clear,   // Hold-off or channel disabled
  input  wire logic raw,     // Threshold exceeded
  input  wire logic dly_en,  // Delay option
  output logic      qual     // Qualified condition
);

  logic [W-1:0] cnt_q;  // Ticks spent above threshold
  logic [W-1:0] cnt_d;

  // Count while above threshold; any dip restarts the wait
  always_comb begin
    cnt_d = cnt_q;
    if (clear || !raw) begin
      cnt_d = '0;
    end else if (tick && cnt_q != W'(LIMIT)) begin
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Immediate when the option is off, else only after the full wait
  assign qual = raw && !clear && (!dly_en || cnt_q == W'(LIMIT));

  a_wait_blocks_qual: assert property (@(posedge clk) disable iff (!rst_n)
    raw && dly_en && cnt_q != W'(LIMIT) |-> !qual)
    else $error("condition qualified before delay elapsed");

  a_no_delay_direct: assert property (@(posedge clk) disable iff (!rst_n)
    raw && !dly_en && !clear |-> qual)
    else $error("undelayed condition not asserted at once");

  a_dip_restarts: assert property (@(posedge clk) disable iff (!rst_n)
    !raw |=> cnt_q == '0 && !$past(qual))
    else $error("delay count not restarted after dip");

endmodule : hold_timer
`default_nettype wire

/* rtl/two_channel_alarm_annunciator.sv */
`timescale 1ns/1ps
`default_nettype none
`include "annunciator_consts.svh"

module two_channel_alarm_annunciator #(
  parameter int TICK_CYCLES       = `TICK_CYCLES,
  parameter int POWERON_TICKS     = `POWERON_TICKS,
  parameter int WARN_DELAY_TICKS  = `WARN_DELAY_TICKS,
  parameter int ALARM_DELAY_TICKS = `WARN_DELAY_TICKS
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] ch1_level_mv,
  input  wire logic [11:0] ch2_level_mv,
  input  wire logic        ch1_warn_hit,
  input  wire logic        ch2_warn_hit,
  input  wire logic        ch1_alarm_hit,
  input  wire logic        ch2_alarm_hit,
  input  wire logic        two_threshold_mode,
  input  wire logic        alarm_ack,
  input  wire logic        fault_drives_alarm_sel,
  input  wire logic        warning_audio_en,
  input  wire logic        fault_level_sel,
  input  wire logic        warning_delay_en,
  input  wire logic        alarm_delay_en,
  input  wire logic        buzzer_master_en,
  input  wire logic        single_relay_group_sel,
  input  wire logic        single_channel_sel,
  input  wire logic        grp1_warn_sense_strap,
  input  wire logic        grp1_alarm_sense_strap,
  input  wire logic        grp2_warn_sense_strap,
  input  wire logic        grp2_alarm_sense_strap,
  output logic             grp1_warn_relay,
  output logic             grp1_alarm_relay,
  output logic             grp2_warn_relay,
  output logic             grp2_alarm_relay,
  output logic             fault_relay,
  output logic             buzzer,
  output logic             power_on_hold
);

  // ---------------------------------------------------------------
  // Timebase and power-on hold
  // ---------------------------------------------------------------
  logic [`TICK_CNT_W-1:0] tick_cnt_q;  // Divider count
  logic [`TICK_CNT_W-1:0] tick_cnt_d;
  logic                   tick_q;      // One-cycle 1 ms enable
  logic                   tick_d;
  logic [`PON_CNT_W-1:0]  pon_cnt_q;   // Ticks since release
  logic [`PON_CNT_W-1:0]  pon_cnt_d;
  logic                   pwr_hold_q;  // Detection suppressed
  logic                   pwr_hold_d;

  // Divider and hold-off count; the hold drops once and stays down
  always_comb begin
    tick_cnt_d = tick_cnt_q + `TICK_CNT_W'(1);
    tick_d     = 1'b0;
    if (tick_cnt_q == `TICK_CNT_W'(TICK_CYCLES - 1)) begin
      tick_cnt_d = '0;
      tick_d     = 1'b1;
    end
    pon_cnt_d  = pon_cnt_q;
    pwr_hold_d = pwr_hold_q;
    if (pwr_hold_q && tick_q) begin
      if (pon_cnt_q == `PON_CNT_W'(POWERON_TICKS - 1)) begin
        pwr_hold_d = 1'b0;
      end else begin
        pon_cnt_d = pon_cnt_q + `PON_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
      pon_cnt_q  <= '0;
      pwr_hold_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
      pon_cnt_q  <= pon_cnt_d;
      pwr_hold_q <= pwr_hold_d;
    end
  end

  // ---------------------------------------------------------------
  // Channel conditions
  // ---------------------------------------------------------------
  logic [1:0]  ch_en;       // Channel in use
  logic [1:0]  warn_raw;    // Warning threshold exceeded
  logic [1:0]  alarm_raw;   // Alarm threshold exceeded
  logic [1:0]  fault_raw;   // Signal below fault level
  logic [1:0]  warn_qual;   // Warning after delay
  logic [1:0]  alarm_qual;  // Alarm after delay
  logic [1:0]  ch_warn;     // Final exclusive states
  logic [1:0]  ch_alarm;
  logic [1:0]  ch_fault;
  logic [11:0] fault_mv;    // Selected fault level

  assign ch_en     = {!single_channel_sel, 1'b1};
  assign warn_raw  = {ch2_warn_hit, ch1_warn_hit};
  assign alarm_raw = {ch2_alarm_hit, ch1_alarm_hit};
  // Lost loop current reads as a low level, so fault is level below limit
  assign fault_mv  = fault_level_sel ? `FAULT_HI_MV : `FAULT_LO_MV;
  assign fault_raw = {ch2_level_mv < fault_mv, ch1_level_mv < fault_mv};

  // One delay qualifier per channel and level
  for (genvar i = 0; i < 2; i++) begin : g_ch
    hold_timer #(
      .W     (`DLY_CNT_W),
      .LIMIT (WARN_DELAY_TICKS)
    ) u_warn_tmr (
      .clk    (clk),
      .rst_n  (rst_n),
      .tick   (tick_q),
      .clear  (pwr_hold_q || !ch_en[i]),
      .raw    (warn_raw[i]),
      .dly_en (warning_delay_en),
      .qual   (warn_qual[i])
    );
    hold_timer #(
      .W     (`DLY_CNT_W),
      .LIMIT (ALARM_DELAY_TICKS)
    ) u_alarm_tmr (
      .clk    (clk),
      .rst_n  (rst_n),
      .tick   (tick_q),
      .clear  (pwr_hold_q || !ch_en[i]),
      .raw    (alarm_raw[i]),
      .dly_en (alarm_delay_en),
      .qual   (alarm_qual[i])
    );
    // Fault outranks alarm, alarm outranks warning, so at most one holds
    assign ch_fault[i] = fault_raw[i] && ch_en[i] && !pwr_hold_q;
    assign ch_alarm[i] = !ch_fault[i] && alarm_qual[i];
    assign ch_warn[i]  = !ch_fault[i] && !alarm_qual[i] && warn_qual[i];
  end

  // ---------------------------------------------------------------
  // Unacknowledged alarm memory
  // ---------------------------------------------------------------
  logic [1:0] unack_q;  // Alarm seen, not yet acknowledged
  logic [1:0] unack_d;

  // A live alarm re-sets the flag even in the acknowledge cycle
  always_comb begin
    unack_d = ch_alarm | (unack_q & {2{!alarm_ack}});
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      unack_q <= '0;
    end else begin
      unack_q <= unack_d;
    end
  end

  // ---------------------------------------------------------------
  // Relay drive
  // ---------------------------------------------------------------
  logic [4:0] relay_q;  // g1 warn, g1 alarm, g2 warn, g2 alarm, fault
  logic [4:0] relay_d;
  logic       g1w, g1a, g2w, g2a;  // Active-condition before sense

  always_comb begin
    if (single_relay_group_sel) begin
      g1w = |ch_warn;
      g1a = |ch_alarm || (fault_drives_alarm_sel && |ch_fault);
      g2w = 1'b0;
      g2a = 1'b0;
    end else begin
      g1w = ch_warn[0];
      g1a = ch_alarm[0] || (fault_drives_alarm_sel && ch_fault[0]);
      g2w = ch_warn[1];
      g2a = ch_alarm[1] || (fault_drives_alarm_sel && ch_fault[1]);
    end
    // A set strap means failsafe: energized at rest, dropped on condition
    relay_d[0] = g1w ^ grp1_warn_sense_strap;
    relay_d[1] = g1a ^ grp1_alarm_sense_strap;
    relay_d[2] = g2w ^ grp2_warn_sense_strap;
    relay_d[3] = g2a ^ grp2_alarm_sense_strap;
    relay_d[4] = |ch_fault;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      relay_q <= '0;
    end else begin
      relay_q <= relay_d;
    end
  end

  // ---------------------------------------------------------------
  // Buzzer pattern select and sequencer
  // ---------------------------------------------------------------
  annunciator_pkg::pat_t        sel;       // Requested pattern
  annunciator_pkg::pat_t        pat_q;     // Pattern in play
  annunciator_pkg::pat_t        pat_d;
  annunciator_pkg::beep_state_t st_q;
  annunciator_pkg::beep_state_t st_d;
  logic [15:0] ms_q;      // Ticks in current phase
  logic [15:0] ms_d;
  logic [2:0]  beep_q;    // Beeps done in this burst
  logic [2:0]  beep_d;
  logic        buzz_q;
  logic        buzz_d;
  logic [15:0] on_len, gap_len, pause_len;  // Pattern timing
  logic [2:0]  nbeeps;
  logic        alarm_req, warn_req, fault_req;

  // Request terms; a fault is quiet while the far channel is busy
  always_comb begin
    alarm_req = |ch_alarm || (!two_threshold_mode && |ch_warn);
    warn_req  = two_threshold_mode && warning_audio_en && |ch_warn;
    fault_req = (ch_fault[0] && !unack_q[1] && !ch_alarm[1] && !ch_warn[1])
             || (ch_fault[1] && !unack_q[0] && !ch_alarm[0] && !ch_warn[0]);
    if (!buzzer_master_en || pwr_hold_q) begin
      sel = annunciator_pkg::PAT_NONE;
    end else if (alarm_req) begin
      sel = annunciator_pkg::PAT_ALARM;
    end else if (warn_req) begin
      sel = annunciator_pkg::PAT_WARN;
    end else if (fault_req) begin
      sel = annunciator_pkg::PAT_FAULT;
    end else begin
      sel = annunciator_pkg::PAT_NONE;
    end
  end

  // Timing of the pattern in play
  always_comb begin
    case (pat_q)
      annunciator_pkg::PAT_WARN: begin
        on_len = `LONG_ON_MS; gap_len = `SLOW_GAP_MS; pause_len = `PAUSE_MS; nbeeps = `WARN_BEEPS;
      end
      annunciator_pkg::PAT_ALARM: begin
        on_len = `SHORT_ON_MS; gap_len = `FAST_GAP_MS; pause_len = `PAUSE_MS; nbeeps = `ALARM_BEEPS;
      end
      annunciator_pkg::PAT_FAULT: begin
        on_len = `SHORT_ON_MS; gap_len = `FAULT_GAP_MS; pause_len = `FAULT_GAP_MS; nbeeps = `FAULT_BEEPS;
      end
      default: begin
        on_len = `SHORT_ON_MS; gap_len = `FAST_GAP_MS; pause_len = `PAUSE_MS; nbeeps = `FAULT_BEEPS;
      end
    endcase
  end

  // A change of pattern restarts at the first beep so bursts stay whole
  always_comb begin
    pat_d  = pat_q;
    st_d   = st_q;
    ms_d   = ms_q;
    beep_d = beep_q;
    if (sel != pat_q) begin
      pat_d  = sel;
      st_d   = (sel == annunciator_pkg::PAT_NONE) ? annunciator_pkg::BS_IDLE : annunciator_pkg::BS_ON;
      ms_d   = '0;
      beep_d = '0;
    end else if (tick_q) begin
      case (st_q)
        annunciator_pkg::BS_ON: begin
          if (ms_q + 16'h0001 >= on_len) begin
            ms_d   = '0;
            beep_d = beep_q + 3'h1;
            st_d   = (beep_q + 3'h1 == nbeeps) ? annunciator_pkg::BS_PAUSE : annunciator_pkg::BS_GAP;
          end else begin
            ms_d = ms_q + 16'h0001;
          end
        end
        annunciator_pkg::BS_GAP: begin
          if (ms_q + 16'h0001 >= gap_len) begin
            ms_d = '0;
            st_d = annunciator_pkg::BS_ON;
          end else begin
            ms_d = ms_q + 16'h0001;
          end
        end
        annunciator_pkg::BS_PAUSE: begin
          if (ms_q + 16'h0001 >= pause_len) begin
            ms_d   = '0;
            beep_d = '0;
            st_d   = annunciator_pkg::BS_ON;
          end else begin
            ms_d = ms_q + 16'h0001;
          end
        end
        default: begin
          st_d = annunciator_pkg::BS_IDLE;
        end
      endcase
    end
    buzz_d = (st_d == annunciator_pkg::BS_ON);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pat_q  <= annunciator_pkg::PAT_NONE;
      st_q   <= annunciator_pkg::BS_IDLE;
      ms_q   <= '0;
      beep_q <= '0;
      buzz_q <= 1'b0;
    end else begin
      pat_q  <= pat_d;
      st_q   <= st_d;
      ms_q   <= ms_d;
      beep_q <= beep_d;
      buzz_q <= buzz_d;
    end
  end

  // Outputs straight from flops
  assign grp1_warn_relay  = relay_q[0];
  assign grp1_alarm_relay = relay_q[1];
  assign grp2_warn_relay  = relay_q[2];
  assign grp2_alarm_relay = relay_q[3];
  assign fault_relay      = relay_q[4];
  assign buzzer           = buzz_q;
  assign power_on_hold    = pwr_hold_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_hold_on;
    pwr_hold_q;
  endsequence
  sequence s_quiet_out;
    !buzzer && !fault_relay && grp1_alarm_relay == $past(grp1_alarm_sense_strap);
  endsequence

  a_fault_no_alarm: assert property (!fault_drives_alarm_sel && ch_alarm == 2'b00
    |=> grp1_alarm_relay == $past(grp1_alarm_sense_strap)) else $error("fault drove alarm relay");
  a_single_grp_fault: assert property (fault_drives_alarm_sel && single_relay_group_sel
    && |ch_fault |=> grp1_alarm_relay != $past(grp1_alarm_sense_strap)) else $error("fault missed alarm");
  a_own_grp_fault: assert property (fault_drives_alarm_sel && !single_relay_group_sel
    && ch_fault == 2'b01 && !ch_alarm[1] |=> grp2_alarm_relay == $past(grp2_alarm_sense_strap)
    && grp1_alarm_relay != $past(grp1_alarm_sense_strap)) else $error("wrong group alarmed");
  a_warn_silent: assert property (two_threshold_mode && !warning_audio_en && ch_alarm == 2'b00
    && ch_fault == 2'b00 |=> !buzzer) else $error("warning sounded with audio off");
  a_master_gate: assert property (!buzzer_master_en |=> !buzzer) else $error("buzzer not gated");
  a_state_exclusive: assert property ($onehot0({ch_warn[0], ch_alarm[0], ch_fault[0]})
    && $onehot0({ch_warn[1], ch_alarm[1], ch_fault[1]})) else $error("states overlap");
  a_poweron_quiet: assert property (s_hold_on |=> s_quiet_out) else $error("output during hold-off");
  a_alarm_first: assert property (buzzer_master_en && !pwr_hold_q && |ch_alarm
    |=> pat_q == annunciator_pkg::PAT_ALARM && (buzzer || $past(pat_q) == annunciator_pkg::PAT_ALARM))
    else $error("alarm pattern not chosen");
  a_alarm_four: assert property (pat_q == annunciator_pkg::PAT_ALARM |-> beep_q <= 3'h4)
    else $error("alarm burst too long");

endmodule : two_channel_alarm_annunciator
`default_nettype wire

/* testbench/sensor_channel_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Stand-in for one gas sensor channel: a commanded status becomes a level and threshold hits
module sensor_channel_model (
  input  wire logic        clk,
  input  wire logic [2:0]  st,         // 0 normal, 1 warning, 2 alarm, 3 fault, 4 weak loop
  output logic      [11:0] level_mv,   // Signal across the termination
  output logic             warn_hit,   // First threshold exceeded
  output logic             alarm_hit   // Second threshold exceeded
);
  // Follows the command at once; the bench moves it only on falling edges,
  // so both channels change together and the block never sees a race
  always_comb begin
    case (st)
      3'h1:    level_mv = 12'h7d0;  // Warning band
      3'h2:    level_mv = 12'hbb8;  // Alarm band
      3'h3:    level_mv = 12'h000;  // Broken loop
      3'h4:    level_mv = 12'h0c8;  // Between the low and high fault levels
      default: level_mv = 12'h3e8;  // Normal, healthy 4 mA loop
    endcase
    warn_hit  = (st == 3'h1);
    alarm_hit = (st == 3'h2);
  end
endmodule : sensor_channel_model

`default_nettype wire

/* testbench/two_channel_alarm_annunciator_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module two_channel_alarm_annunciator_tb;
  logic        clk, rst_n;                  // Clock and synchronous reset
  logic [2:0]  st1, st2;                    // Commanded channel status
  logic [11:0] lv1, lv2;                    // Channel levels
  logic        w1, w2, a1, a2;              // Threshold hits
  logic        two_thr, ack, f2a, waud;     // Mode and option switches
  logic        flev, wdly, adly, bmen;
  logic        one_grp, one_ch;
  logic        s1w, s1a, s2w, s2a;          // Relay sense straps
  logic        r1w, r1a, r2w, r2a, rf, bz;  // Relay and buzzer outputs
  logic        hold;                        // Power-on hold-off
  int          failures, cmp_count, cyc;

  sensor_channel_model m1 (.clk(clk), .st(st1), .level_mv(lv1), .warn_hit(w1), .alarm_hit(a1));
  sensor_channel_model m2 (.clk(clk), .st(st2), .level_mv(lv2), .warn_hit(w2), .alarm_hit(a2));

  // Short timebase keeps the hold-off and delays to a few dozen clocks
  two_channel_alarm_annunciator #(.TICK_CYCLES(4), .POWERON_TICKS(5), .WARN_DELAY_TICKS(6),
    .ALARM_DELAY_TICKS(6)) dut (
    .clk(clk), .rst_n(rst_n), .ch1_level_mv(lv1), .ch2_level_mv(lv2),
    .ch1_warn_hit(w1), .ch2_warn_hit(w2), .ch1_alarm_hit(a1), .ch2_alarm_hit(a2),
    .two_threshold_mode(two_thr), .alarm_ack(ack), .fault_drives_alarm_sel(f2a),
    .warning_audio_en(waud), .fault_level_sel(flev), .warning_delay_en(wdly),
    .alarm_delay_en(adly), .buzzer_master_en(bmen), .single_relay_group_sel(one_grp),
    .single_channel_sel(one_ch), .grp1_warn_sense_strap(s1w), .grp1_alarm_sense_strap(s1a),
    .grp2_warn_sense_strap(s2w), .grp2_alarm_sense_strap(s2a), .grp1_warn_relay(r1w),
    .grp1_alarm_relay(r1a), .grp2_warn_relay(r2w), .grp2_alarm_relay(r2a),
    .fault_relay(rf), .buzzer(bz), .power_on_hold(hold));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  // Runaway guard, well above the longest pattern walk
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk

  task automatic chk_len(input string nm, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      failures++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : chk_len

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : cycles

  // Length of the buzzer's stay at val, in clocks; four clocks per pattern millisecond
  task automatic span(input string nm, input logic val, input int lo, input int hi);
    int n;
    n = 0;
    while (bz === val && n < hi + 10) begin
      @(negedge clk);
      n++;
    end
    chk_len(nm, lo, hi, n);
  endtask : span

  // Buzzer must hold val for n clocks on end; a long stay cannot be timed by span
  task automatic steady(input string nm, input logic val, input int n);
    int   bad;
    logic seen;
    bad  = 0;
    seen = val;
    repeat (n) begin
      @(negedge clk);
      if (bz !== val) begin
        bad++;
        seen = bz;
      end
    end
    cmp_count++;
    if (bad != 0) begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", nm, val, seen);
    end
  endtask : steady

  // Model follows at once and the block needs one rising edge, so allow three
  task automatic set_st(input logic [2:0] c1, input logic [2:0] c2);
    @(negedge clk);
    st1 = c1;
    st2 = c2;
    cycles(3);
  endtask : set_st

  // Clears alarm memory and returns to all normal
  task automatic quiet();
    ack = 1'b1;
    set_st(3'h0, 3'h0);
    ack = 1'b0;
    cycles(1);
  endtask : quiet

  task automatic t_hold();
    int n;
    st1 = 3'h2;
    bmen = 1'b1;
    cycles(3);
    chk("alarm relay in hold", 1'b0, r1a);
    chk("buzzer in hold", 1'b0, bz);
    n = 3;
    while (hold === 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk_len("hold length", 19, 23, n);
    cycles(3);
    chk("alarm relay after hold", 1'b1, r1a);
    chk("buzzer after hold", 1'b1, bz);
    bmen = 1'b0;
    quiet();
  endtask : t_hold

  task automatic t_relays();
    set_st(3'h3, 3'h0);
    chk("fault relay ch1", 1'b1, rf);
    chk("alarm1 fault opt off", 1'b0, r1a);
    chk("buzzer master off", 1'b0, bz);
    f2a = 1'b1;
    set_st(3'h3, 3'h0);
    chk("alarm1 own group", 1'b1, r1a);
    chk("alarm2 other group", 1'b0, r2a);
    set_st(3'h0, 3'h3);
    chk("alarm1 not own group", 1'b0, r1a);
    chk("alarm2 own group", 1'b1, r2a);
    one_grp = 1'b1;
    set_st(3'h0, 3'h3);
    chk("single alarm relay", 1'b1, r1a);
    one_ch = 1'b1;
    set_st(3'h0, 3'h3);
    chk("disabled ch2 fault", 1'b0, rf);
    chk("disabled ch2 alarm", 1'b0, r1a);
    f2a = 1'b0;
    one_grp = 1'b0;
    one_ch = 1'b0;
    set_st(3'h4, 3'h0);
    chk("weak loop low level", 1'b0, rf);
    flev = 1'b1;
    set_st(3'h4, 3'h0);
    chk("weak loop high level", 1'b1, rf);
    flev = 1'b0;
    quiet();
  endtask : t_relays

  task automatic t_groups();
    set_st(3'h1, 3'h2);
    chk("warn1 from ch1", 1'b1, r1w);
    chk("alarm1 idle", 1'b0, r1a);
    chk("warn2 idle", 1'b0, r2w);
    chk("alarm2 from ch2", 1'b1, r2a);
    s1w = 1'b1;
    s1a = 1'b1;
    s2w = 1'b1;
    s2a = 1'b1;
    set_st(3'h1, 3'h2);
    chk("warn1 failsafe", 1'b0, r1w);
    chk("alarm1 failsafe", 1'b1, r1a);
    chk("warn2 failsafe", 1'b1, r2w);
    chk("alarm2 failsafe", 1'b0, r2a);
    s1w = 1'b0;
    s1a = 1'b0;
    s2w = 1'b0;
    s2a = 1'b0;
    quiet();
  endtask : t_groups

  // Six ticks of four clocks, plus tick alignment
  task automatic t_delay();
    int n;
    wdly = 1'b1;
    adly = 1'b1;
    @(negedge clk);
    st1 = 3'h1;
    st2 = 3'h2;
    n = 0;
    while (r1w !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk_len("warning delay", 22, 36, n);
    chk("alarm delay", 1'b1, r2a);
    wdly = 1'b0;
    adly = 1'b0;
    quiet();
  endtask : t_delay

  task automatic t_buzz();
    bmen = 1'b1;
    set_st(3'h1, 3'h0);
    steady("warning silent", 1'b0, 600);
    waud = 1'b1;
    span("warning lead", 1'b0, 0, 20);
    span("warning beep 1", 1'b1, 1990, 2010);
    span("warning gap", 1'b0, 1990, 2010);
    span("warning beep 2", 1'b1, 1990, 2010);
    span("warning pause", 1'b0, 3990, 6010);
    bmen = 1'b0;
    cycles(3);
    steady("master off", 1'b0, 3000);
    bmen = 1'b1;
    quiet();
    chk("normal silent", 1'b0, bz);
    set_st(3'h0, 3'h2);
    span("alarm lead", 1'b0, 0, 20);
    for (int i = 0; i < 3; i++) begin
      span("alarm beep", 1'b1, 395, 405);
      span("alarm gap", 1'b0, 395, 405);
    end
    span("alarm beep 4", 1'b1, 395, 405);
    span("alarm pause", 1'b0, 3990, 4410);
    quiet();
    two_thr = 1'b0;
    waud = 1'b0;
    set_st(3'h1, 3'h0);
    span("single level lead", 1'b0, 0, 20);
    span("single level beep", 1'b1, 395, 405);
    two_thr = 1'b1;
    waud = 1'b1;
    quiet();
    set_st(3'h3, 3'h1);
    span("warn over fault lead", 1'b0, 0, 20);
    span("warn over fault", 1'b1, 1990, 2010);
    quiet();
    set_st(3'h3, 3'h2);
    span("alarm over fault lead", 1'b0, 0, 20);
    span("alarm over fault", 1'b1, 395, 405);
    span("alarm over fault gap", 1'b0, 395, 405);
    set_st(3'h3, 3'h0);
    steady("fault with unacked", 1'b0, 5000);
    ack = 1'b1;
    cycles(2);
    ack = 1'b0;
    span("fault lead", 1'b0, 0, 20);
    span("fault beep", 1'b1, 395, 405);
    span("fault gap", 1'b0, 3595, 3605);
    quiet();
  endtask : t_buzz

  // Main sequence
  initial begin
    failures = 0;
    cmp_count = 0;
    cyc = 0;
    rst_n = 1'b0;
    {st1, st2} = 6'h00;
    {two_thr, ack, f2a, waud, flev, wdly, adly} = 7'h40;
    {bmen, one_grp, one_ch, s1w, s1a, s2w, s2a} = 7'h00;
    cycles(2);
    chk("hold in reset", 1'b1, hold);
    chk("fault relay in reset", 1'b0, rf);
    rst_n = 1'b1;
    t_hold();
    t_relays();
    t_groups();
    t_delay();
    t_buzz();
    report_and_stop();
  end
endmodule : two_channel_alarm_annunciator_tb

`default_nettype wire
